// *** pcr_pkg.sv ***
// Behaviour
// - Three straps give core-two ratio: 011 1.5, 100 2, 101 2.5, 110 3, 111 3.5.
// - Three strap pins give memory PLL ratio: 3, 4, 6, 8, 10 for codes 000-100.
// - Memory select code 111 means synchronous memory clocking; reference clock unused.
// - In synchronous mode memory bus clock runs at half the bus clock.
// - Data rate follows bus clock when synchronous, memory PLL when asynchronous.
// - Memory complex clock equals data rate; ratio is data rate to reference.
// - Both memory controllers always share one clocking mode.
// - Shared 125 MHz reference used only when a port runs GMII, TBI, RGMII or RTBI.
// - General-purpose straps are latched for software and steer no hardware.
`default_nettype none
package pcr_pkg;
    // ======================================================
    // Widths
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int CODE_W     = 3;
    localparam int GP_W       = 8;
    localparam int STRAP_W    = 2 * CODE_W + GP_W;
    localparam int MULT_W     = 4;
    localparam int PORTS      = 4;
    localparam int ETH_MODE_W = 3;
    localparam int CNT_W      = 4;

    // ======================================================
    // Strap vector layout
    localparam int STRAP_CORE_LSB = 11;
    localparam int STRAP_DDR_LSB  = 8;
    localparam int STRAP_GP_LSB   = 0;

    // ======================================================
    // Codes
    localparam logic [CODE_W-1:0] CORE_MIN_CODE = 3'h3;
    localparam logic [CODE_W-1:0] DDR_CODE_3    = 3'h0;
    localparam logic [CODE_W-1:0] DDR_CODE_4    = 3'h1;
    localparam logic [CODE_W-1:0] DDR_CODE_6    = 3'h2;
    localparam logic [CODE_W-1:0] DDR_CODE_8    = 3'h3;
    localparam logic [CODE_W-1:0] DDR_CODE_10   = 3'h4;
    localparam logic [CODE_W-1:0] DDR_SYNC_CODE = 3'h7;
    localparam logic [MULT_W-1:0] MULT_3        = 4'h3;
    localparam logic [MULT_W-1:0] MULT_4        = 4'h4;
    localparam logic [MULT_W-1:0] MULT_6        = 4'h6;
    localparam logic [MULT_W-1:0] MULT_8        = 4'h8;
    localparam logic [MULT_W-1:0] MULT_10       = 4'hA;
    localparam logic [MULT_W-1:0] MULT_NONE     = 4'h0;

    localparam logic [ETH_MODE_W-1:0] ETH_GMII  = 3'h1;
    localparam logic [ETH_MODE_W-1:0] ETH_TBI   = 3'h2;
    localparam logic [ETH_MODE_W-1:0] ETH_RGMII = 3'h3;
    localparam logic [ETH_MODE_W-1:0] ETH_RTBI  = 3'h4;

    // ======================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int STRAP_SETTLE_NS = 1000;
    localparam logic [CNT_W-1:0] SETTLE_CYC =
        CNT_W'((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ======================================================
    // Register map
    localparam logic [ADDR_W-1:0] REG_CORE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DDR  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_GP   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h10;

    localparam int RSVD_BIT          = 8;
    localparam int MODE_CAPTURED_BIT = 0;
    localparam int MODE_SYNC_BIT     = 1;
    localparam int MODE_REF_USED_BIT = 2;
    localparam int MODE_GTX_USED_BIT = 3;
    localparam int MODE_PLL_RATE_BIT = 4;
    localparam int CTRL_CLK_EN_BIT   = 0;
    localparam logic CTRL_CLK_EN_RESET = 1'b1;

    typedef enum logic [1:0] {
        CAP_SETTLE = 2'b00,
        CAP_WAIT   = 2'b01,
        CAP_HELD   = 2'b10
    } pcr_cap_state_t;
endpackage
`default_nettype wire

// *** pcr_strap_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcr_strap_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] value,
    output logic              stable
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign value  = s3_reg;
    assign stable = (s2_reg == s3_reg);
endmodule
`default_nettype wire

// *** pcr_clk_half.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcr_clk_half (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic run,
    output logic      clk_out
);
    logic div_reg;

    // Toggle each rising edge: half the input rate, low when stopped
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            div_reg <= 1'b0;
        else if (run)
            div_reg <= ~div_reg;
        else
            div_reg <= 1'b0;
    end

    assign clk_out = div_reg;
endmodule
`default_nettype wire

// *** por_clock_ratio_decode.sv ***
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module por_clock_ratio_decode (
    input  wire logic                                  clock,
    input  wire logic                                  rst_b,
    input  wire logic                                  local_bus_write_strap,
    input  wire logic                                  serial_out_one_strap,
    input  wire logic                                  second_core_ready_strap,
    input  wire logic                                  timestamp_clock_out_strap,
    input  wire logic                                  timestamp_pulse_a_strap,
    input  wire logic                                  timestamp_pulse_b_strap,
    input  wire logic [pcr_pkg::GP_W-1:0]              gp_strap,
    input  wire logic [pcr_pkg::PORTS*pcr_pkg::ETH_MODE_W-1:0] eth_port_mode,
    input  wire logic [pcr_pkg::ADDR_W-1:0]            reg_addr,
    input  wire logic [pcr_pkg::DATA_W-1:0]            reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic      [pcr_pkg::DATA_W-1:0]            reg_rdata,
    output logic                                       strap_pullup_en,
    output logic                                       straps_captured,
    output logic      [pcr_pkg::CODE_W-1:0]            core_ratio_x2,
    output logic                                       core_ratio_reserved,
    output logic      [pcr_pkg::MULT_W-1:0]            ddr_pll_mult,
    output logic                                       ddr_ratio_invalid,
    output logic                                       ddr0_sync_mode,
    output logic                                       ddr1_sync_mode,
    output logic                                       ddr_rate_from_pll,
    output logic                                       ddr_ref_clock_used,
    output logic                                       gigabit_ref_used,
    output logic                                       ddr_bus_clk
);
    // ======================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_b;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_b   <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_b   <= rst_meta_reg;
        end
    end

    // ======================================================
    // Strap synchronisers
    logic [pcr_pkg::STRAP_W-1:0] strap_pins;
    logic [pcr_pkg::STRAP_W-1:0] strap_val;
    logic                        strap_stable;

    assign strap_pins = {local_bus_write_strap, serial_out_one_strap,
                         second_core_ready_strap, timestamp_clock_out_strap,
                         timestamp_pulse_a_strap, timestamp_pulse_b_strap, gp_strap};

    pcr_strap_sync #(
        .W (pcr_pkg::STRAP_W)
    ) u_sync (
        .clock  (clock),
        .rst_b  (rst_sync_b),
        .pins   (strap_pins),
        .value  (strap_val),
        .stable (strap_stable)
    );

    // ======================================================
    // Capture sequencer
    pcr_pkg::pcr_cap_state_t    cap_state_reg;
    logic [pcr_pkg::CNT_W-1:0]  settle_cnt_reg;
    logic                       capture;

    assign capture = (cap_state_reg == pcr_pkg::CAP_WAIT) && strap_stable;

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cap_state_reg  <= pcr_pkg::CAP_SETTLE;
            settle_cnt_reg <= '0;
        end
        else
        begin
            case (cap_state_reg)
                pcr_pkg::CAP_SETTLE:
                begin
                    if (settle_cnt_reg == pcr_pkg::SETTLE_CYC)
                        cap_state_reg <= pcr_pkg::CAP_WAIT;
                    else
                        settle_cnt_reg <= settle_cnt_reg + 1'b1;
                end
                pcr_pkg::CAP_WAIT:
                begin
                    if (strap_stable)
                        cap_state_reg <= pcr_pkg::CAP_HELD;
                end
                pcr_pkg::CAP_HELD:
                    cap_state_reg <= pcr_pkg::CAP_HELD;
                default:
                    cap_state_reg <= pcr_pkg::CAP_SETTLE;
            endcase
        end
    end

    // Weak pull-up only until straps are taken
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            strap_pullup_en <= 1'b1;
            straps_captured <= 1'b0;
        end
        else if (capture)
        begin
            strap_pullup_en <= 1'b0;
            straps_captured <= 1'b1;
        end
    end

    // ======================================================
    // Latched codes
    logic [pcr_pkg::CODE_W-1:0] core_code;
    logic [pcr_pkg::CODE_W-1:0] ddr_code;
    logic [pcr_pkg::CODE_W-1:0] ddr_code_reg;
    logic [pcr_pkg::GP_W-1:0]   gp_reg;

    assign core_code = strap_val[pcr_pkg::STRAP_CORE_LSB +: pcr_pkg::CODE_W];
    assign ddr_code  = strap_val[pcr_pkg::STRAP_DDR_LSB +: pcr_pkg::CODE_W];

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            core_ratio_x2       <= '0;
            core_ratio_reserved <= 1'b0;
        end
        else if (capture)
        begin
            if (core_code < pcr_pkg::CORE_MIN_CODE)
            begin
                core_ratio_x2       <= '0;
                core_ratio_reserved <= 1'b1;
            end
            else
            begin
                core_ratio_x2       <= core_code;
                core_ratio_reserved <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ddr_code_reg      <= '0;
            ddr_pll_mult      <= pcr_pkg::MULT_NONE;
            ddr_ratio_invalid <= 1'b0;
        end
        else if (capture)
        begin
            ddr_code_reg      <= ddr_code;
            ddr_ratio_invalid <= 1'b0;
            case (ddr_code)
                pcr_pkg::DDR_CODE_3:    ddr_pll_mult <= pcr_pkg::MULT_3;
                pcr_pkg::DDR_CODE_4:    ddr_pll_mult <= pcr_pkg::MULT_4;
                pcr_pkg::DDR_CODE_6:    ddr_pll_mult <= pcr_pkg::MULT_6;
                pcr_pkg::DDR_CODE_8:    ddr_pll_mult <= pcr_pkg::MULT_8;
                pcr_pkg::DDR_CODE_10:   ddr_pll_mult <= pcr_pkg::MULT_10;
                pcr_pkg::DDR_SYNC_CODE: ddr_pll_mult <= pcr_pkg::MULT_NONE;
                default:
                begin
                    ddr_pll_mult      <= pcr_pkg::MULT_NONE;
                    ddr_ratio_invalid <= 1'b1;
                end
            endcase
        end
    end

    // Software-only copy, wired to nothing else
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            gp_reg <= '0;
        else if (capture)
            gp_reg <= strap_val[pcr_pkg::STRAP_GP_LSB +: pcr_pkg::GP_W];
    end

    // ======================================================
    // Memory clocking mode
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ddr0_sync_mode     <= 1'b0;
            ddr1_sync_mode     <= 1'b0;
            ddr_rate_from_pll  <= 1'b0;
            ddr_ref_clock_used <= 1'b0;
        end
        else if (capture)
        begin
            ddr0_sync_mode     <= (ddr_code == pcr_pkg::DDR_SYNC_CODE);
            ddr1_sync_mode     <= (ddr_code == pcr_pkg::DDR_SYNC_CODE);
            ddr_rate_from_pll  <= (ddr_code != pcr_pkg::DDR_SYNC_CODE);
            ddr_ref_clock_used <= (ddr_code != pcr_pkg::DDR_SYNC_CODE);
        end
    end

    // ======================================================
    // Shared gigabit reference
    logic [pcr_pkg::PORTS-1:0] port_needs_ref;

    for (genvar p = 0; p < pcr_pkg::PORTS; p++)
    begin : g_port
        logic [pcr_pkg::ETH_MODE_W-1:0] m;
        assign m = eth_port_mode[p*pcr_pkg::ETH_MODE_W +: pcr_pkg::ETH_MODE_W];
        assign port_needs_ref[p] = (m == pcr_pkg::ETH_GMII) || (m == pcr_pkg::ETH_TBI)
                                || (m == pcr_pkg::ETH_RGMII) || (m == pcr_pkg::ETH_RTBI);
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            gigabit_ref_used <= 1'b0;
        else
            gigabit_ref_used <= |port_needs_ref;
    end

    // ======================================================
    // Register file
    logic ctrl_clk_en_reg;

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            ctrl_clk_en_reg <= pcr_pkg::CTRL_CLK_EN_RESET;
        else if (reg_wr && reg_addr == pcr_pkg::REG_CTRL)
            ctrl_clk_en_reg <= reg_wdata[pcr_pkg::CTRL_CLK_EN_BIT];
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            reg_rdata <= '0;
        else
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                case (reg_addr)
                    pcr_pkg::REG_CORE:
                    begin
                        reg_rdata[pcr_pkg::CODE_W-1:0] <= core_ratio_x2;
                        reg_rdata[pcr_pkg::RSVD_BIT]   <= core_ratio_reserved;
                    end
                    pcr_pkg::REG_DDR:
                    begin
                        reg_rdata[pcr_pkg::MULT_W-1:0] <= ddr_pll_mult;
                        reg_rdata[pcr_pkg::RSVD_BIT]   <= ddr_ratio_invalid;
                    end
                    pcr_pkg::REG_MODE:
                    begin
                        reg_rdata[pcr_pkg::MODE_CAPTURED_BIT] <= straps_captured;
                        reg_rdata[pcr_pkg::MODE_SYNC_BIT]     <= ddr0_sync_mode;
                        reg_rdata[pcr_pkg::MODE_REF_USED_BIT] <= ddr_ref_clock_used;
                        reg_rdata[pcr_pkg::MODE_GTX_USED_BIT] <= gigabit_ref_used;
                        reg_rdata[pcr_pkg::MODE_PLL_RATE_BIT] <= ddr_rate_from_pll;
                    end
                    pcr_pkg::REG_GP:
                        reg_rdata[pcr_pkg::GP_W-1:0] <= gp_reg;
                    pcr_pkg::REG_CTRL:
                        reg_rdata[pcr_pkg::CTRL_CLK_EN_BIT] <= ctrl_clk_en_reg;
                    default:
                        reg_rdata <= '0;
                endcase
            end
        end
    end

    // ======================================================
    // Synchronous memory bus clock
    pcr_clk_half u_half (
        .clock   (clock),
        .rst_b   (rst_sync_b),
        .run     (ddr0_sync_mode && ctrl_clk_en_reg),
        .clk_out (ddr_bus_clk)
    );

    // ======================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_b);

    chk_core_reserved: assert property (
        straps_captured && core_ratio_reserved |-> core_ratio_x2 == 3'h0)
        else $error("reserved core code gave a ratio");
    chk_core_map: assert property (
        capture && core_code >= pcr_pkg::CORE_MIN_CODE |=> core_ratio_x2 == $past(core_code))
        else $error("core ratio does not follow strap code");
    chk_ddr_ten: assert property (
        capture && ddr_code == 3'h4 |=> ddr_pll_mult == 4'hA && !ddr0_sync_mode)
        else $error("code 100 did not give ratio ten");
    chk_sync_select: assert property (
        straps_captured |-> ddr0_sync_mode == (ddr_code_reg == 3'h7))
        else $error("sync mode does not match code 111");
    chk_ref_unused: assert property (
        ddr0_sync_mode |-> !ddr_ref_clock_used && ddr_pll_mult == 4'h0)
        else $error("reference clock used in sync mode");
    chk_half_rate: assert property (
        ddr0_sync_mode && ctrl_clk_en_reg ##1 ddr0_sync_mode && ctrl_clk_en_reg
        |-> ddr_bus_clk != $past(ddr_bus_clk))
        else $error("memory bus clock not at half rate");
    chk_rate_source: assert property (
        straps_captured |-> ddr_rate_from_pll == !ddr0_sync_mode)
        else $error("data rate source wrong for mode");
    chk_same_mode: assert property (
        ddr0_sync_mode == ddr1_sync_mode)
        else $error("controllers in different modes");
    chk_gtx_ref: assert property (
        ##1 gigabit_ref_used == $past(|port_needs_ref))
        else $error("gigabit reference use flag wrong");
    chk_pullup_window: assert property (
        (cap_state_reg == pcr_pkg::CAP_HELD) == !strap_pullup_en)
        else $error("pull-up enabled outside capture window");
    chk_hold_codes: assert property (
        straps_captured |=> $stable(core_ratio_x2) && $stable(ddr_pll_mult)
                            && $stable(gp_reg) && straps_captured)
        else $error("captured codes changed");

    cov_sync_mode: cover property (capture && ddr_code == 3'h7);
    cov_async_ten: cover property (capture && ddr_code == 3'h4);
    cov_core_rsvd: cover property (capture && core_code == 3'h0);
    cov_gtx_used:  cover property ($rose(gigabit_ref_used));
endmodule
`default_nettype wire

// *** pcr_strap_board.sv ***
`timescale 1ns/1ns
`default_nettype none
// ======================================================
// Board straps: resistors hold levels, open pins float
module pcr_strap_board (
    input  wire logic        clock,
    input  wire logic        pullup_en,
    input  wire logic [13:0] level,
    input  wire logic [13:0] open_mask,
    output logic      [13:0] pins
);
    logic toggle_reg = 1'b0;

    // Floating pin wanders once the weak pull-up is off
    always @(posedge clock)
    begin
        toggle_reg <= ~toggle_reg;
    end

    always_comb
    begin
        pins = (level & ~open_mask) | (open_mask & {14{pullup_en | toggle_reg}});
    end
endmodule
`default_nettype wire

// *** test_por_clock_ratio_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_por_clock_ratio_decode;
    logic        clock;
    logic        rst_b;
    logic [13:0] level;
    logic [13:0] open_mask;
    wire  [13:0] pins;
    logic [11:0] eth;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    wire  [31:0] rdata;
    wire         pullup_en;
    wire         captured;
    wire  [2:0]  core_x2;
    wire         core_rsvd;
    wire  [3:0]  mult;
    wire         ddr_bad;
    wire         sync0;
    wire         sync1;
    wire         from_pll;
    wire         ref_used;
    wire         gig_used;
    wire         bus_clk;
    int          fails;
    int          n_tests;

    pcr_strap_board u_pcr_strap_board (.clock(clock), .pullup_en(pullup_en), .level(level),
        .open_mask(open_mask), .pins(pins));

    por_clock_ratio_decode u_por_clock_ratio_decode (.clock(clock), .rst_b(rst_b),
        .local_bus_write_strap(pins[13]), .serial_out_one_strap(pins[12]),
        .second_core_ready_strap(pins[11]), .timestamp_clock_out_strap(pins[10]),
        .timestamp_pulse_a_strap(pins[9]), .timestamp_pulse_b_strap(pins[8]),
        .gp_strap(pins[7:0]), .eth_port_mode(eth), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .strap_pullup_en(pullup_en),
        .straps_captured(captured), .core_ratio_x2(core_x2), .core_ratio_reserved(core_rsvd),
        .ddr_pll_mult(mult), .ddr_ratio_invalid(ddr_bad), .ddr0_sync_mode(sync0),
        .ddr1_sync_mode(sync1), .ddr_rate_from_pll(from_pll), .ddr_ref_clock_used(ref_used),
        .gigabit_ref_used(gig_used), .ddr_bus_clk(bus_clk));

    initial clock = 1'b0;
    always #50 clock = ~clock;

    // ======================================================
    // Helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic boot(input logic [2:0] c, input logic [2:0] m, input logic [7:0] g,
                        input logic [13:0] om);
        @(posedge clock);
        level <= {c, m, g};
        open_mask <= om;
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        #1 chk("pullup_in_reset", 1, pullup_en);
        @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 40 && captured !== 1'b1; i++)
            @(posedge clock);
        #1 chk("captured", 1, captured);
        chk("pullup_after", 0, pullup_en);
    endtask

    function automatic logic [3:0] exp_mult(input logic [2:0] m);
        case (m)
            3'h0: return 4'h3;
            3'h1: return 4'h4;
            3'h2: return 4'h6;
            3'h3: return 4'h8;
            3'h4: return 4'hA;
            default: return 4'h0;
        endcase
    endfunction

    task automatic expect_decode(input logic [2:0] c, input logic [2:0] m, input logic [7:0] g);
        logic [31:0] d;
        logic        s;
        s = (m == 3'h7);
        chk("core_x2", (c >= 3'h3) ? c : 3'h0, core_x2);
        chk("core_rsvd", c < 3'h3, core_rsvd);
        chk("mult", exp_mult(m), mult);
        chk("ddr_bad", m == 3'h5 || m == 3'h6, ddr_bad);
        chk("sync0", s, sync0);
        chk("sync1", s, sync1);
        chk("from_pll", !s, from_pll);
        chk("ref_used", !s, ref_used);
        reg_read(8'h00, d);
        chk("reg_core", {23'h0, c < 3'h3, 5'h0, (c >= 3'h3) ? c : 3'h0}, d);
        reg_read(8'h04, d);
        chk("reg_ddr", {23'h0, m == 3'h5 || m == 3'h6, 4'h0, exp_mult(m)}, d);
        reg_read(8'h08, d);
        chk("reg_mode", {27'h0, !s, 1'b0, !s, s, 1'b1}, d);
        reg_read(8'h0C, d);
        chk("reg_gp", {24'h0, g}, d);
    endtask

    // ======================================================
    // Scenarios
    task automatic t_codes;
        for (int i = 0; i < 8; i++)
        begin
            boot(3'(i), 3'(7 - i), 8'hA5 ^ 8'(i), 14'h0);
            expect_decode(3'(i), 3'(7 - i), 8'hA5 ^ 8'(i));
        end
        $display("test codes done");
    endtask

    task automatic t_bus_clk;
        logic [31:0] d;
        logic        p;
        boot(3'h4, 3'h7, 8'h00, 14'h0);
        reg_read(8'h10, d);
        chk("ctrl_reset", 1, d);
        for (int i = 0; i < 4; i++)
        begin
            p = bus_clk;
            @(posedge clock);
            #1 chk("bus_clk_toggle", !p, bus_clk);
        end
        reg_write(8'h10, 32'h0);
        repeat (2) @(posedge clock);
        #1 chk("bus_clk_off", 0, bus_clk);
        boot(3'h4, 3'h2, 8'h00, 14'h0);
        repeat (3) @(posedge clock);
        #1 chk("bus_clk_async", 0, bus_clk);
        $display("test bus clock done");
    endtask

    task automatic t_hold;
        logic [31:0] d;
        boot(3'h0, 3'h0, 8'h00, 14'h3FFF);
        @(posedge clock);
        level <= 14'h1234;
        open_mask <= 14'h0;
        repeat (10) @(posedge clock);
        expect_decode(3'h7, 3'h7, 8'hFF);
        reg_write(8'h0C, 32'h0);
        reg_write(8'h00, 32'h0);
        reg_read(8'h14, d);
        chk("unmapped", 0, d);
        expect_decode(3'h7, 3'h7, 8'hFF);
        $display("test hold done");
    endtask

    task automatic t_eth;
        logic [31:0] d;
        for (int p = 0; p < 4; p++)
            for (int m = 0; m < 8; m++)
            begin
                @(posedge clock);
                eth <= 12'(m) << (3 * p);
                repeat (2) @(posedge clock);
                #1 chk("gig_used", m >= 1 && m <= 4, gig_used);
            end
        reg_read(8'h08, d);
        chk("mode_gig", 0, d[3]);
        @(posedge clock);
        eth <= 12'h200;
        repeat (3) @(posedge clock);
        reg_read(8'h08, d);
        chk("mode_gig_on", 1, d[3]);
        $display("test ethernet done");
    endtask

    // ======================================================
    // Verdict
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (6000) @(posedge clock);
        fails++;
        wrap_up();
    end

    initial
    begin
        fails = 0;
        n_tests = 0;
        rst_b <= 1'b0;
        level <= 14'h0;
        open_mask <= 14'h0;
        eth <= 12'h0;
        addr <= 8'h0;
        wdata <= 32'h0;
        wr <= 1'b0;
        rd <= 1'b0;
        t_codes();
        t_bus_clk();
        t_hold();
        t_eth();
        wrap_up();
    end
endmodule
`default_nettype wire
